// file: hw/sdsq_pkg.sv
// constants of the segment display sequencer: register map, fields, rates.
// assumes a 40 MHz system clock and a classic wishbone register bus.
package sdsq_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [9:0] IDX_BLINK_FRAME_CLOCK = 10'h096;
    localparam logic [9:0] IDX_CONFIG_X = 10'h09c;
    localparam logic [9:0] IDX_CONFIG_Y = 10'h0b1;
    localparam logic [9:0] IDX_CONTROL = 10'h0c0;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0c1;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0c2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // display_blink_frame_clock fields
    localparam int BFC_SOURCE_LSB = 6;
    localparam int BFC_RATE_LSB = 4;
    localparam int BFC_DIV_LSB = 0;
    // display_config_x fields
    localparam int CX_LADDER_BIT = 6;
    localparam int CX_LEVEL_TOP = 5;
    // display_config_y fields
    localparam int CY_ROTATE_BIT = 7;
    localparam int CY_FLIP_BIT = 6;
    localparam int CY_PAGE_LSB = 2;
    localparam int CY_DONE_BIT = 1;
    localparam int CY_HOLD_BIT = 0;
    localparam logic [7:0] CY_WRITE_MASK = 8'hcd;
    // control fields
    localparam int CT_THIRD_BIT = 2;
    localparam int CT_SLOW_BIT = 3;
    localparam int CT_BLINK_BIT = 4;
    localparam int CT_CONTRAST_BIT = 5;
    localparam logic [7:0] CT_WRITE_MASK = 8'h3f;
    // interrupt status bits
    localparam int IRQ_UPDATE_BIT = 0;
    localparam int IRQ_FRAME_BIT = 1;
    localparam int IRQ_STEP_BIT = 2;
    localparam logic [7:0] IRQ_WRITE_MASK = 8'h07;
    // clock rates
    localparam int CLK_HZ = 40000000;
    localparam int FAST_HZ = 2048;
    localparam int SLOW_HZ = 128;
    localparam int FAST_DIV = CLK_HZ / FAST_HZ;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    // a quarter second in display clock ticks
    localparam logic [9:0] FAST_QUARTER = 10'(FAST_HZ / 4);
    localparam logic [9:0] SLOW_QUARTER = 10'(SLOW_HZ / 4);
    // fixed auto blink of 2 Hz toggles every quarter second
    localparam logic [3:0] QUARTERS_2HZ = 4'h1;
    localparam int CONTRAST_FULL = 31;
    typedef enum logic [1:0] {SDSQ_SRC_OFF, SDSQ_SRC_ON, SDSQ_SRC_2HZ, SDSQ_SRC_RATE} sdsq_src_t;
    typedef enum logic [1:0] {SDSQ_COM_RSVD, SDSQ_COM_TWO, SDSQ_COM_THREE, SDSQ_COM_FOUR}
        sdsq_com_t;
endpackage

// file: hw/sdsq_tick_div.sv
// tick divider: a one-cycle pulse every div_i enabled cycles.
// assumes div_i is at least one; a change of div_i takes effect on the next count.
`timescale 1ns/1ps
`default_nettype none
module sdsq_tick_div #(
    parameter int W = 19
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // count control
    input wire logic en_i,
    input wire logic [W-1:0] div_i,
    // pulse out
    output logic tick_o
);
    logic [W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (en_i) begin
            // compare against div-1 so a shrinking divisor never overruns
            if (cnt_q >= div_i - W'(1)) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

    tick_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |-> $past(en_i)) else $error("tick without enable");
    tick_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |-> $past(cnt_q) >= $past(div_i) - W'(1))
        else $error("tick before count reached");
endmodule
`default_nettype wire

// file: hw/sdsq_core.sv
// segment display sequencer: display clock, segment/frame timing, blink, page rotation,
// hold/update handshake and contrast encoding, with classic wishbone registers.
// assumes a 40 MHz clk_i, synchronous active high reset, one outstanding bus cycle.
`timescale 1ns/1ps
`default_nettype none
module sdsq_core import sdsq_pkg::*; #(
    parameter int FAST_CYCLES = FAST_DIV,
    parameter int SLOW_CYCLES = SLOW_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // panel timing
    output logic seg_tick_o,
    output logic frame_start_o,
    output logic [1:0] com_index_o,
    output logic [1:0] com_count_o,
    output logic polarity_o,
    output logic display_on_o,
    output logic [1:0] page_o,
    output logic load_o,
    // bias generation
    output logic pump_en_o,
    output logic ladder_en_o,
    output logic third_bias_o,
    output logic contrast_en_o,
    output logic [6:0] bias_a_o,
    output logic [8:0] bias_b_o,
    output logic [8:0] bias_c_o,
    // interrupt
    output logic irq_o
);
    // segment clock divisor in display clock ticks
    function automatic logic [7:0] seg_div(input logic slow, input logic [1:0] com,
                                           input logic [3:0] fd);
        logic [7:0] d;
        d = 8'h00;
        if (!slow) begin
            if (fd == 4'h0) d = (com == SDSQ_COM_THREE || com == SDSQ_COM_FOUR) ? 8'h40 : 8'h80;
            else if (com == SDSQ_COM_THREE || com == SDSQ_COM_FOUR) begin
                d = {3'h0, fd, 1'b0} + 8'h02;
                if (d < 8'h06) d = 8'h06;
                if (com == SDSQ_COM_FOUR && fd == 4'h1) d = 8'h04;
            end else d = {2'h0, fd, 2'h0} + 8'h04;
        end else begin
            if (fd == 4'hf) d = 8'h01;
            else if (fd == 4'h0) d = 8'h02;
            else if (com == SDSQ_COM_THREE || com == SDSQ_COM_FOUR) d = 8'h04;
            else if (fd == 4'h1) d = 8'h04;
            else if (fd == 4'h2) d = 8'h06;
            else d = 8'h08;
        end
        return d;
    endfunction

    // quarter seconds per blink or rotation step
    function automatic logic [3:0] step_quarters(input logic [1:0] rate);
        return {1'b0, rate, 1'b0} + 4'h2;
    endfunction

    // ---------------- registers and bus ----------------
    logic [7:0] bfc_q, bfc_d, cx_q, cx_d, cy_q, cy_d, ct_q, ct_d, ist_q, ist_d, imsk_q, imsk_d;
    logic ack_q, ack_d, pend_q, pend_d;
    logic [31:0] rdat_q, rdat_d;
    logic req, wr, rd, done_set, frame_start, step;
    logic [9:0] idx;
    logic [7:0] wbyte, rbyte;

    assign req = cyc_i && stb_i;
    assign idx = adr_i[11:2];
    assign wr = req && ack_q && we_i && sel_i[0];
    assign rd = req && ack_q && !we_i;
    assign wbyte = dat_i[7:0];

    always_comb begin
        rbyte = 8'h00;
        case (idx)
            IDX_BLINK_FRAME_CLOCK: rbyte = bfc_q;
            IDX_CONFIG_X: rbyte = cx_q;
            IDX_CONFIG_Y: rbyte = cy_q;
            IDX_CONTROL: rbyte = ct_q;
            IDX_IRQ_STATUS: rbyte = ist_q;
            IDX_IRQ_MASK: rbyte = imsk_q;
            default: rbyte = 8'h00;
        endcase
    end

    always_comb begin
        ack_d = req && !ack_q;
        rdat_d = (req && !ack_q) ? {24'h000000, rbyte} : rdat_q;
        bfc_d = bfc_q;
        cx_d = cx_q;
        cy_d = cy_q;
        ct_d = ct_q;
        imsk_d = imsk_q;
        ist_d = ist_q;
        pend_d = pend_q;
        if (wr) begin
            case (idx)
                IDX_BLINK_FRAME_CLOCK: bfc_d = wbyte;
                IDX_CONFIG_X: cx_d = wbyte & 8'h7f;
                IDX_CONFIG_Y: begin
                    // reserved bits stay zero; the done flag only accepts a zero
                    cy_d = (cy_q & ~CY_WRITE_MASK) | (wbyte & CY_WRITE_MASK);
                    if (!wbyte[CY_DONE_BIT]) cy_d[CY_DONE_BIT] = 1'b0;
                    if (wbyte[CY_HOLD_BIT] && !cy_q[CY_HOLD_BIT])
                        cy_d[CY_DONE_BIT] = 1'b0;
                    if (!wbyte[CY_HOLD_BIT] && cy_q[CY_HOLD_BIT]) pend_d = 1'b1;
                end
                IDX_CONTROL: ct_d = wbyte & CT_WRITE_MASK;
                IDX_IRQ_MASK: imsk_d = wbyte & IRQ_WRITE_MASK;
                default: ;
            endcase
        end
        if (rd && idx == IDX_IRQ_STATUS) ist_d = ist_q & ~rdat_q[7:0]; // later events survive
        // set wins over any clear in the same cycle
        if (done_set) begin
            cy_d[CY_DONE_BIT] = 1'b1;
            pend_d = 1'b0;
            ist_d[IRQ_UPDATE_BIT] = 1'b1;
        end
        if (frame_start) ist_d[IRQ_FRAME_BIT] = 1'b1;
        if (step) ist_d[IRQ_STEP_BIT] = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bfc_q <= RESET_BYTE;
            cx_q <= RESET_BYTE;
            cy_q <= RESET_BYTE;
            ct_q <= RESET_BYTE;
            ist_q <= RESET_BYTE;
            imsk_q <= RESET_BYTE;
            ack_q <= 1'b0;
            pend_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            bfc_q <= bfc_d;
            cx_q <= cx_d;
            cy_q <= cy_d;
            ct_q <= ct_d;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            ack_q <= ack_d;
            pend_q <= pend_d;
            rdat_q <= rdat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign irq_o = |(ist_q & imsk_q);

    // ---------------- timing ----------------
    logic slow, hold, rotate, flip, blink_en;
    logic [1:0] com, src, rate;
    logic [1:0] ncom_m1;
    logic [18:0] disp_div;
    logic disp_tick, seg_tick, qtick;
    logic [1:0] com_q, com_d, page_q, page_d;
    logic pol_q, pol_d, phase_q, phase_d, load_q, load_d, fs_q, fs_d;
    logic [9:0] qcnt_q, qcnt_d, quarter;
    logic [3:0] hcnt_q, hcnt_d, need;
    logic on_q, on_d;

    assign slow = ct_q[CT_SLOW_BIT];
    assign com = ct_q[1:0];
    assign blink_en = ct_q[CT_BLINK_BIT];
    assign hold = cy_q[CY_HOLD_BIT];
    assign rotate = cy_q[CY_ROTATE_BIT];
    assign flip = cy_q[CY_FLIP_BIT];
    assign src = bfc_q[BFC_SOURCE_LSB +: 2];
    assign rate = bfc_q[BFC_RATE_LSB +: 2];
    // reserved code 00 runs as two commons
    assign ncom_m1 = (com == SDSQ_COM_RSVD) ? 2'h1 : com;
    assign disp_div = slow ? 19'(SLOW_CYCLES) : 19'(FAST_CYCLES);
    assign quarter = slow ? SLOW_QUARTER : FAST_QUARTER;
    assign need = (!rotate && src == SDSQ_SRC_2HZ) ? QUARTERS_2HZ : step_quarters(rate);

    sdsq_tick_div #(.W(19)) u_disp_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(1'b1),
        .div_i(disp_div),
        .tick_o(disp_tick)
    );

    sdsq_tick_div #(.W(8)) u_seg_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(disp_tick),
        .div_i(seg_div(slow, com, bfc_q[BFC_DIV_LSB +: 4])),
        .tick_o(seg_tick)
    );

    assign frame_start = seg_tick && (com_q >= ncom_m1);
    assign qtick = disp_tick && (qcnt_q >= quarter - 10'h001);
    assign step = qtick && (hcnt_q >= need - 4'h1);
    assign done_set = frame_start && !hold && pend_q;

    always_comb begin
        com_d = com_q;
        if (seg_tick) com_d = frame_start ? 2'h0 : com_q + 2'h1;
        if (com_q > ncom_m1) com_d = 2'h0;
        pol_d = flip ? (frame_start ? !pol_q : pol_q) : 1'b0;
        qcnt_d = disp_tick ? (qtick ? 10'h000 : qcnt_q + 10'h001) : qcnt_q;
        hcnt_d = qtick ? (step ? 4'h0 : hcnt_q + 4'h1) : hcnt_q;
        phase_d = step ? !phase_q : phase_q;
        page_d = cy_q[CY_PAGE_LSB +: 2];
        if (rotate) page_d = step ? page_q + 2'h1 : page_q;
        load_d = frame_start && !hold;
        fs_d = frame_start;
        on_d = 1'b1;
        if (blink_en && !rotate) begin
            case (src)
                SDSQ_SRC_OFF: on_d = 1'b0;
                SDSQ_SRC_ON: on_d = 1'b1;
                default: on_d = phase_q;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            com_q <= 2'h0;
            pol_q <= 1'b0;
            qcnt_q <= 10'h000;
            hcnt_q <= 4'h0;
            phase_q <= 1'b0;
            page_q <= 2'h0;
            load_q <= 1'b0;
            fs_q <= 1'b0;
            on_q <= 1'b0;
        end else begin
            com_q <= com_d;
            pol_q <= pol_d;
            qcnt_q <= qcnt_d;
            hcnt_q <= hcnt_d;
            phase_q <= phase_d;
            page_q <= page_d;
            load_q <= load_d;
            fs_q <= fs_d;
            on_q <= on_d;
        end
    end

    assign seg_tick_o = seg_tick;
    assign frame_start_o = fs_q;
    assign com_index_o = com_q;
    assign com_count_o = ncom_m1;
    assign polarity_o = pol_q;
    assign display_on_o = on_q;
    assign page_o = page_q;
    assign load_o = load_q;

    // ---------------- bias ----------------
    logic [6:0] va;
    assign va = {1'b0, cx_q[4:0]} + (cx_q[CX_LEVEL_TOP] ? 7'(CONTRAST_FULL) : 7'h00);
    assign ladder_en_o = cx_q[CX_LADDER_BIT];
    assign pump_en_o = !cx_q[CX_LADDER_BIT];
    assign third_bias_o = ct_q[CT_THIRD_BIT];
    assign contrast_en_o = ct_q[CT_CONTRAST_BIT];
    // levels in units of reference/31, zero while contrast control is off
    assign bias_a_o = contrast_en_o ? va : 7'h00;
    assign bias_b_o = third_bias_o ? {1'b0, bias_a_o, 1'b0} : {2'h0, bias_a_o};
    assign bias_c_o = third_bias_o ? {2'h0, bias_a_o} + {1'b0, bias_a_o, 1'b0}
                                   : {1'b0, bias_a_o, 1'b0};

    // ---------------- checks ----------------
    rotate_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rotate && step |=> page_q == $past(page_q) + 2'h1) else $error("page did not advance");
    rotate_noblink_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rotate |=> display_on_o) else $error("blink during rotation");
    flip_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
        flip && frame_start |=> polarity_o != $past(polarity_o)) else $error("no inversion");
    flip_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !flip |=> !polarity_o) else $error("inversion while off");
    page_pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rotate |=> page_o == $past(cy_q[CY_PAGE_LSB +: 2])) else $error("wrong page");
    done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_start && !hold && pend_q |=> cy_q[CY_DONE_BIT] && load_o) else $error("no done");
    hold_noload_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(hold) |-> !load_o) else $error("load during hold");
    release_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_start && !hold |=> load_o && frame_start_o) else $error("missed load");
    blink_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && !rotate && src == SDSQ_SRC_OFF |=> !display_on_o) else $error("not off");
    fast_blink_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !rotate && src == SDSQ_SRC_2HZ && qtick |-> step) else $error("2 Hz step missed");
    rate_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step |-> hcnt_q >= step_quarters(rate) - 4'h1 || need == QUARTERS_2HZ)
        else $error("early step");
    frame_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        frame_start |-> seg_tick && (com_q == ncom_m1 || $past(com) != com))
        else $error("frame not on last common");
    bias_mult_a: assert property (@(posedge clk_i) disable iff (rst_i)
        third_bias_o |-> bias_c_o == {2'h0, bias_a_o} * 9'h003) else $error("bias c wrong");
    com_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        com_q <= ncom_m1 || $past(com) != com) else $error("common index out of range");
    done_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_CONFIG_Y && !wbyte[CY_DONE_BIT] && !done_set |=> !cy_q[CY_DONE_BIT])
        else $error("done not cleared");
    ladder_pump_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pump_en_o != ladder_en_o) else $error("pump and ladder both on");

    update_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) done_set);
    rotate_wrap_c: cover property (@(posedge clk_i) disable iff (rst_i)
        rotate && step && page_q == 2'h3);
    blink_toggle_c: cover property (@(posedge clk_i) disable iff (rst_i)
        blink_en && src == SDSQ_SRC_RATE && step);
endmodule
`default_nettype wire

// file: bench/sdsq_glass_model.sv
// passive glass model: measures segment and frame periods, counts loads and
// keeps the drive polarity of the last two frames; assumes one-cycle pulse inputs.
`timescale 1ns/1ps
`default_nettype none
module sdsq_glass_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // panel timing
    input wire logic seg_tick_i,
    input wire logic frame_start_i,
    input wire logic polarity_i,
    input wire logic load_i,
    // observations
    output var int seg_period_o,
    output var int frame_period_o,
    output var int loads_o,
    output logic [1:0] pol_hist_o
);
    int seg_cnt_q;
    int frm_cnt_q;
    logic frm_dly_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seg_cnt_q <= 0;
            frm_cnt_q <= 0;
            seg_period_o <= 0;
            frame_period_o <= 0;
            loads_o <= 0;
            frm_dly_q <= 1'b0;
            pol_hist_o <= 2'h0;
        end else begin
            seg_cnt_q <= seg_tick_i ? 0 : seg_cnt_q + 1;
            frm_cnt_q <= frame_start_i ? 0 : frm_cnt_q + 1;
            if (seg_tick_i)
                seg_period_o <= seg_cnt_q + 1;
            if (frame_start_i)
                frame_period_o <= frm_cnt_q + 1;
            if (load_i)
                loads_o <= loads_o + 1;
            frm_dly_q <= frame_start_i;
            // sampled a cycle late so a flip launched with the frame pulse has landed
            if (frm_dly_q)
                pol_hist_o <= {pol_hist_o[0], polarity_i};
        end
    end
endmodule
`default_nettype wire

// file: bench/segment_display_sequencer_tb_top.sv
// bench for the segment display sequencer: wishbone master, reference model, glass model.
// assumes the shortened display clock dividers and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
module segment_display_sequencer_tb_top;
    import sdsq_pkg::*;
    localparam int FC = 4;
    localparam int SC = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_o;
    logic ack_o, seg_tick_o, frame_start_o, polarity_o, display_on_o, load_o, irq_o;
    logic pump_en_o, ladder_en_o, third_bias_o, contrast_en_o;
    logic [1:0] com_index_o, com_count_o, page_o, pol_h;
    logic [6:0] bias_a_o;
    logic [8:0] bias_b_o, bias_c_o;
    logic [7:0] q;
    logic [9:0] regs [5];
    int seg_p, frm_p, loads, seed_r, off_cnt = 0, miscompares = 0, samples_checked = 0;
    int fds [4] = '{1, 2, 15, 0};
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) off_cnt <= off_cnt + ((display_on_o !== 1'b1) ? 1 : 0);
    sdsq_core #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
        .dat_o(dat_o), .ack_o(ack_o), .seg_tick_o(seg_tick_o), .frame_start_o(frame_start_o),
        .com_index_o(com_index_o), .com_count_o(com_count_o), .polarity_o(polarity_o),
        .display_on_o(display_on_o), .page_o(page_o), .load_o(load_o), .pump_en_o(pump_en_o),
        .ladder_en_o(ladder_en_o), .third_bias_o(third_bias_o), .contrast_en_o(contrast_en_o),
        .bias_a_o(bias_a_o), .bias_b_o(bias_b_o), .bias_c_o(bias_c_o), .irq_o(irq_o));
    sdsq_glass_model glass_u (.clk_i(clk_i), .rst_i(rst_i), .seg_tick_i(seg_tick_o),
        .frame_start_i(frame_start_o), .polarity_i(polarity_o), .load_i(load_o),
        .seg_period_o(seg_p), .frame_period_o(frm_p), .loads_o(loads), .pol_hist_o(pol_h));
    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d,
                      output logic [7:0] x);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'h1;
        dat_w <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 100);
        if (n >= 100)
            miscompares++;
        x = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [7:0] x;
        wb(1'b1, i, d, x);
    endtask
    task automatic rd(input logic [9:0] i, output logic [7:0] x);
        wb(1'b0, i, 8'h00, x);
    endtask
    task automatic wait_frames(input int k);
        int n;
        n = 0;
        repeat (k) begin
            @(posedge clk_i);
            n++;
            while (frame_start_o !== 1'b1 && n < 20000) begin
                @(posedge clk_i);
                n++;
            end
        end
        if (n >= 20000)
            miscompares++;
    endtask
    function automatic logic [1:0] cur(input bit pg);
        return pg ? page_o : {1'b0, display_on_o};
    endfunction
    // first change aligns, second change closes one full step
    task automatic gap(input bit pg, output logic [1:0] a, output logic [1:0] b, output int len);
        int n;
        a = cur(pg);
        n = 0;
        while (cur(pg) === a && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        a = cur(pg);
        len = 0;
        while (cur(pg) === a && len < 5000) begin
            @(posedge clk_i);
            len++;
        end
        b = cur(pg);
    endtask
    // segment clock divisor in display clock ticks
    function automatic int seg_div(int s, int c, int fd);
        if (s != 0)
            return (fd == 0) ? 2 : (fd == 15) ? 1 : (c >= 2) ? 4 : (fd == 1) ? 4 : (fd == 2) ? 6 : 8;
        if (c < 2)
            return (fd == 0) ? 128 : 4 * (fd + 1);
        if (fd == 0)
            return 64;
        if (c == 3 && fd == 1)
            return 4;
        return (2 * (fd + 1) < 6) ? 6 : 2 * (fd + 1);
    endfunction
    initial begin
        repeat (90000) @(posedge clk_i);
        miscompares++;
        stop_test();
    end
    initial begin
        int d, n, t, src, r, o;
        logic [1:0] a, b;
        seed_r = $urandom(32'h86f358ee);
        regs = '{IDX_BLINK_FRAME_CLOCK, IDX_CONFIG_X, IDX_CONFIG_Y, IDX_CONTROL, 10'h3ff};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(10'h3ff, 8'hff);
        foreach (regs[i]) begin
            rd(regs[i], q);
            chk(q, RESET_BYTE);
        end
        for (int s = 0; s < 2; s++) for (int c = 0; c < 4; c++) foreach (fds[j]) begin
            wr(IDX_CONTROL, 8'(s * 8 + c));
            wr(IDX_BLINK_FRAME_CLOCK, 8'(fds[j]));
            wait_frames(2);
            @(negedge clk_i);
            chk(com_index_o, 0);
            d = seg_div(s, c, fds[j]) * ((s != 0) ? SC : FC);
            n = (c < 2) ? 2 : c + 1;
            chk(seg_p, d);
            chk(frm_p, d * n);
            chk(com_count_o, n - 1);
        end
        wr(IDX_CONTROL, 8'h19);
        for (int k = 0; k < 7; k++) begin
            src = (k < 3) ? k : 3;
            r = (k < 3) ? 0 : k - 3;
            wr(IDX_BLINK_FRAME_CLOCK, 8'(src * 64 + r * 16 + 1));
            if (src < 2) begin
                repeat (4) @(posedge clk_i);
                chk(display_on_o, src);
            end else begin
                gap(1'b0, a, b, n);
                chk(n, ((src == 2) ? 1 : 2 * (r + 1)) * 32 * SC);
            end
        end
        wr(IDX_CONFIG_Y, 8'h80);
        wr(IDX_BLINK_FRAME_CLOCK, 8'hc1);
        repeat (2) @(posedge clk_i);
        o = off_cnt;
        gap(1'b1, a, b, n);
        chk(n, 2 * 32 * SC);
        chk(b, 2'(a + 2'h1));
        chk(off_cnt - o, 0);
        wr(IDX_CONTROL, 8'h01);
        wr(IDX_BLINK_FRAME_CLOCK, 8'h0f);
        for (int p = 0; p < 4; p++) begin
            wr(IDX_CONFIG_Y, 8'(p * 4));
            rd(IDX_CONFIG_Y, q);
            chk(q, p * 4);
            chk(page_o, p);
        end
        wr(IDX_CONFIG_Y, 8'h40);
        wait_frames(3);
        chk(^pol_h, 1);
        wr(IDX_CONFIG_Y, 8'h00);
        wait_frames(3);
        chk(pol_h, 0);
        // processor side of the handshake: hold, change nothing unsafe, release
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_CONFIG_Y, 8'h01);
        rd(IDX_CONFIG_Y, q);
        chk(q, 8'h01);
        o = loads;
        wait_frames(2);
        chk(loads - o, 0);
        rd(IDX_IRQ_STATUS, q);
        wr(IDX_CONFIG_Y, 8'h00);
        wait_frames(2);
        repeat (2) @(posedge clk_i);
        chk(loads > o, 1);
        rd(IDX_CONFIG_Y, q);
        chk(q, 8'h02);
        chk(irq_o, 0);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1);
        rd(IDX_IRQ_STATUS, q);
        chk(q & 8'h01, 1);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 0);
        wr(IDX_CONFIG_Y, 8'h03);
        rd(IDX_CONFIG_Y, q);
        chk(q, 8'h01);
        wr(IDX_CONFIG_Y, 8'h02);
        wait_frames(2);
        rd(IDX_CONFIG_Y, q);
        chk(q, 8'h02);
        wr(IDX_CONFIG_Y, 8'h00);
        rd(IDX_CONFIG_Y, q);
        chk(q, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = $urandom & 127;
            t = $urandom & 1;
            wr(IDX_CONFIG_X, 8'(d));
            wr(IDX_CONTROL, 8'(8'h21 | (t * 4)));
            rd(IDX_CONFIG_X, q);
            chk(q, d);
            n = (d & 31) + 31 * ((d >> 5) & 1);
            chk(bias_a_o, n);
            chk(bias_b_o, (t != 0) ? 2 * n : n);
            chk(bias_c_o, (t != 0) ? 3 * n : 2 * n);
            chk(third_bias_o, t);
            chk(contrast_en_o, 1);
            chk(ladder_en_o, d >> 6);
            chk(pump_en_o, (d >> 6) ^ 1);
        end
        wr(IDX_CONTROL, 8'h01);
        repeat (2) @(posedge clk_i);
        chk(bias_a_o, 0);
        chk(contrast_en_o, 0);
        stop_test();
    end
endmodule
`default_nettype wire
